// [rtl/gpp_ext_sense.sv]
`default_nettype none

module gpp_ext_sense
  import gpp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       pin_sync,
  input  wire gpp_sense_t sense,
  output logic            trig,
  output logic            level_low
);

  logic prev;

  // ==========================================================
  // Previous sample for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) prev <= 1'b0;  // Same as synchroniser reset level
    else         prev <= pin_sync;
  end

  // Trigger decode from the sense field
  always_comb begin
    level_low = !pin_sync;
    unique case (sense)
      SENSE_LOW:  trig = 1'b0;
      SENSE_ANY:  trig = pin_sync ^ prev;
      SENSE_FALL: trig = prev & !pin_sync;
      SENSE_RISE: trig = !prev & pin_sync;
    endcase
  end

endmodule : gpp_ext_sense

`default_nettype wire

// [rtl/gpp_pkg.sv]
// Summary of operation
// - External request needs mask bit 6 and global enable
// - External pin fires even when driven as output
// - Group one: enabled pins 11..8 change raises request
// - Group zero: enabled pins 7..0 change raises request
// - Reserved mask and flag bits read zero
// - External activity sets flag bit 6, vectors when enabled
// - External flag clears on service or written one
// - Low-level sensing keeps external flag cleared
// - Pins 11..8 change sets flag bit 1
// - Pins 7..0 change sets flag bit 0
// - Pin-change flags clear on service or written one
// - Pin counts only with mask and group enable
// - Each port has output, direction, pull-up, input
// - Writing one to input register toggles output bit
// - Direction one is output, zero is input
// - Output pin drives its output value bit
// - Pull-up follows its enable bit, any direction
// - Reset tri-states all pins without a clock
// - Single-bit operations change only the addressed bit
// - Other pins stay general I/O beside alternates
// - Sense field: low, any change, falling, rising
// - Low-level mode requests while pin is low
// - Input register samples through a synchroniser
`default_nettype none

package gpp_pkg;

  // ==========================================================
  // I/O address map
  localparam int          IO_AW          = 6;
  localparam logic [5:0]  ADDR_PCMSK_LOW  = 6'h12;
  localparam logic [5:0]  ADDR_PCMSK_HIGH = 6'h13;
  localparam logic [5:0]  ADDR_B_IN       = 6'h15;
  localparam logic [5:0]  ADDR_B_DIR      = 6'h16;
  localparam logic [5:0]  ADDR_B_OUT      = 6'h17;
  localparam logic [5:0]  ADDR_B_PUE      = 6'h18;
  localparam logic [5:0]  ADDR_A_IN       = 6'h19;
  localparam logic [5:0]  ADDR_A_DIR      = 6'h1A;
  localparam logic [5:0]  ADDR_A_OUT      = 6'h1B;
  localparam logic [5:0]  ADDR_A_PUE      = 6'h1C;
  localparam logic [5:0]  ADDR_SENSE      = 6'h35;
  localparam logic [5:0]  ADDR_GIFLAGS    = 6'h3A;
  localparam logic [5:0]  ADDR_GIMASK     = 6'h3B;

  // ==========================================================
  // Field positions and writable masks
  localparam int          GIM_EXT_BIT    = 6;
  localparam int          GIM_PC1_BIT    = 5;
  localparam int          GIM_PC0_BIT    = 4;
  localparam int          FLG_EXT_BIT    = 6;
  localparam int          FLG_PC1_BIT    = 1;
  localparam int          FLG_PC0_BIT    = 0;
  localparam logic [7:0]  GIM_RW_MASK    = 8'h70;
  localparam logic [7:0]  FLG_RW_MASK    = 8'h43;
  localparam logic [7:0]  PCMSK_HIGH_RW  = 8'h0F;
  localparam logic [7:0]  SENSE_RW_MASK  = 8'h03;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam int          EXT_PIN        = 10;
  localparam int          PORT_A_W       = 8;
  localparam int          PORT_B_W       = 4;
  localparam int          SYNC_CYCLES    = 2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } gpp_sense_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       bset;
    logic       bclr;
    logic [2:0] bitsel;
  } gpp_io_req_t;

  // ==========================================================
  // Register update for write, bit set and bit clear
  function automatic logic [7:0] gpp_update(input logic [7:0]  cur,
                                            input gpp_io_req_t req);
    logic [7:0] one;
    one = 8'h01 << req.bitsel;
    if (req.wr)        gpp_update = req.wdata;
    else if (req.bset) gpp_update = cur | one;
    else if (req.bclr) gpp_update = cur & ~one;
    else               gpp_update = cur;
  endfunction : gpp_update

  // Bits written as one by a write or a bit set
  function automatic logic [7:0] gpp_ones(input gpp_io_req_t req);
    if (req.wr)        gpp_ones = req.wdata;
    else if (req.bset) gpp_ones = 8'h01 << req.bitsel;
    else               gpp_ones = 8'h00;
  endfunction : gpp_ones

endpackage : gpp_pkg

`default_nettype wire

// [rtl/gpp_port.sv]
`default_nettype none

module gpp_port
  import gpp_pkg::*;
#(
  parameter int         W        = 8,
  parameter logic [5:0] ADDR_IN  = 6'h19,
  parameter logic [5:0] ADDR_DIR = 6'h1A,
  parameter logic [5:0] ADDR_OUT = 6'h1B,
  parameter logic [5:0] ADDR_PUE = 6'h1C
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire gpp_io_req_t req,
  input  wire logic [W-1:0] pin_in,
  output logic [W-1:0]      dir,
  output logic [W-1:0]      outv,
  output logic [W-1:0]      pue,
  output logic [W-1:0]      pin_sync
);

  logic [W-1:0] sync_1;
  logic [7:0]   next_dir;
  logic [7:0]   next_out;
  logic [7:0]   next_pue;
  logic [7:0]   tog;

  // ==========================================================
  // Input synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_1   <= '0;
      pin_sync <= '0;
    end else begin
      sync_1   <= pin_in;
      pin_sync <= sync_1;
    end
  end

  // ==========================================================
  // Next values; bit ops touch only the addressed bit
  always_comb begin
    tog      = (req.addr == ADDR_IN) ? gpp_ones(req) : 8'h00;
    next_dir = (req.addr == ADDR_DIR) ? gpp_update(8'(dir), req)
                                      : 8'(dir);
    next_pue = (req.addr == ADDR_PUE) ? gpp_update(8'(pue), req)
                                      : 8'(pue);
    next_out = (req.addr == ADDR_OUT) ? gpp_update(8'(outv), req)
                                      : 8'(outv) ^ tog;
  end

  // Direction register, cleared at once by reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) dir <= '0;
    else         dir <= next_dir[W-1:0];
  end

  // Output value register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) outv <= '0;
    else         outv <= next_out[W-1:0];
  end

  // Pull-up enable register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pue <= '0;
    else         pue <= next_pue[W-1:0];
  end

endmodule : gpp_port

`default_nettype wire

// [rtl/gpp_top.sv]
`default_nettype none

module gpp_top
  import gpp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire gpp_io_req_t io_req,
  output logic [7:0]       io_rdata,
  input  wire logic        gie,
  input  wire logic [2:0]  irq_ack,
  output logic [2:0]       irq_req,
  input  wire logic [11:0] pin_in,
  output logic [11:0]      pin_out,
  output logic [11:0]      pin_oe_n,
  output logic [11:0]      pin_pullup
);

  logic [7:0]  gimask;
  logic [7:0]  giflags;
  logic [7:0]  pcmsk_low;
  logic [7:0]  pcmsk_high;
  logic [7:0]  sense_reg;
  logic [7:0]  next_rdata;
  logic [7:0]  flag_clr;
  logic [11:0] dir;
  logic [11:0] outv;
  logic [11:0] pue;
  logic [11:0] pin_sync;
  logic [11:0] pin_prev;
  logic [11:0] pin_chg;
  logic        ext_trig;
  logic        ext_low;
  logic        ext_level;
  logic        set_ext;
  logic        set_pc0;
  logic        set_pc1;
  gpp_sense_t  sense;

  // ==========================================================
  // Ports: A holds pins 7..0, B holds pins 11..8
  gpp_port #(
    .W        (PORT_A_W),
    .ADDR_IN  (ADDR_A_IN),
    .ADDR_DIR (ADDR_A_DIR),
    .ADDR_OUT (ADDR_A_OUT),
    .ADDR_PUE (ADDR_A_PUE)
  ) u_port_a (
    .clk      (clk),
    .arst_n   (arst_n),
    .req      (io_req),
    .pin_in   (pin_in[7:0]),
    .dir      (dir[7:0]),
    .outv     (outv[7:0]),
    .pue      (pue[7:0]),
    .pin_sync (pin_sync[7:0])
  );

  gpp_port #(
    .W        (PORT_B_W),
    .ADDR_IN  (ADDR_B_IN),
    .ADDR_DIR (ADDR_B_DIR),
    .ADDR_OUT (ADDR_B_OUT),
    .ADDR_PUE (ADDR_B_PUE)
  ) u_port_b (
    .clk      (clk),
    .arst_n   (arst_n),
    .req      (io_req),
    .pin_in   (pin_in[11:8]),
    .dir      (dir[11:8]),
    .outv     (outv[11:8]),
    .pue      (pue[11:8]),
    .pin_sync (pin_sync[11:8])
  );

  // ==========================================================
  // Pin drivers; each pin is set up on its own, so pins
  // taken by other functions leave the rest untouched
  assign pin_out    = outv;
  assign pin_oe_n   = ~dir;
  assign pin_pullup = pue;

  // ==========================================================
  // External sense; the synchronised pin is sampled whatever
  // its direction, so software can raise the request itself
  assign sense = gpp_sense_t'(sense_reg[1:0]);

  gpp_ext_sense u_ext (
    .clk       (clk),
    .arst_n    (arst_n),
    .pin_sync  (pin_sync[EXT_PIN]),
    .sense     (sense),
    .trig      (ext_trig),
    .level_low (ext_low)
  );

  // ==========================================================
  // Pin change detection on synchronised samples
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pin_prev <= '0;
    else         pin_prev <= pin_sync;
  end

  always_comb begin
    pin_chg = pin_sync ^ pin_prev;
    set_pc0 = |(pin_chg[7:0] & pcmsk_low)
              & gimask[GIM_PC0_BIT];
    set_pc1 = |(pin_chg[11:8] & pcmsk_high[3:0])
              & gimask[GIM_PC1_BIT];
    set_ext = ext_trig;
    ext_level = (sense == SENSE_LOW);
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) gimask <= REG_RESET;
    else if (io_req.addr == ADDR_GIMASK)
      gimask <= gpp_update(gimask, io_req) & GIM_RW_MASK;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pcmsk_low <= REG_RESET;
    else if (io_req.addr == ADDR_PCMSK_LOW)
      pcmsk_low <= gpp_update(pcmsk_low, io_req);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pcmsk_high <= REG_RESET;
    else if (io_req.addr == ADDR_PCMSK_HIGH)
      pcmsk_high <= gpp_update(pcmsk_high, io_req) & PCMSK_HIGH_RW;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sense_reg <= REG_RESET;
    else if (io_req.addr == ADDR_SENSE)
      sense_reg <= gpp_update(sense_reg, io_req) & SENSE_RW_MASK;
  end

  // ==========================================================
  // Flags: written one or service clears, a set wins
  always_comb begin
    flag_clr = (io_req.addr == ADDR_GIFLAGS) ? gpp_ones(io_req)
                                             : 8'h00;
    flag_clr[FLG_EXT_BIT] = flag_clr[FLG_EXT_BIT] | irq_ack[0];
    flag_clr[FLG_PC0_BIT] = flag_clr[FLG_PC0_BIT] | irq_ack[1];
    flag_clr[FLG_PC1_BIT] = flag_clr[FLG_PC1_BIT] | irq_ack[2];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      giflags <= REG_RESET;
    end else begin
      if (ext_level)
        giflags[FLG_EXT_BIT] <= 1'b0;
      else
        giflags[FLG_EXT_BIT] <= set_ext
          | (giflags[FLG_EXT_BIT] & !flag_clr[FLG_EXT_BIT]);
      giflags[FLG_PC0_BIT] <= set_pc0
        | (giflags[FLG_PC0_BIT] & !flag_clr[FLG_PC0_BIT]);
      giflags[FLG_PC1_BIT] <= set_pc1
        | (giflags[FLG_PC1_BIT] & !flag_clr[FLG_PC1_BIT]);
    end
  end

  // ==========================================================
  // Requests to the core, gated by global enable
  always_comb begin
    irq_req[0] = gie & gimask[GIM_EXT_BIT]
      & (ext_level ? ext_low : giflags[FLG_EXT_BIT]);
    irq_req[1] = gie & gimask[GIM_PC0_BIT]
      & giflags[FLG_PC0_BIT];
    irq_req[2] = gie & gimask[GIM_PC1_BIT]
      & giflags[FLG_PC1_BIT];
  end

  // ==========================================================
  // Read data, registered; unmapped reads return zero
  always_comb begin
    unique case (io_req.addr)
      ADDR_A_IN:       next_rdata = pin_sync[7:0];
      ADDR_A_DIR:      next_rdata = dir[7:0];
      ADDR_A_OUT:      next_rdata = outv[7:0];
      ADDR_A_PUE:      next_rdata = pue[7:0];
      ADDR_B_IN:       next_rdata = {4'h0, pin_sync[11:8]};
      ADDR_B_DIR:      next_rdata = {4'h0, dir[11:8]};
      ADDR_B_OUT:      next_rdata = {4'h0, outv[11:8]};
      ADDR_B_PUE:      next_rdata = {4'h0, pue[11:8]};
      ADDR_PCMSK_LOW:  next_rdata = pcmsk_low;
      ADDR_PCMSK_HIGH: next_rdata = pcmsk_high;
      ADDR_SENSE:      next_rdata = sense_reg;
      ADDR_GIMASK:     next_rdata = gimask & GIM_RW_MASK;
      ADDR_GIFLAGS:    next_rdata = giflags & FLG_RW_MASK;
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)        io_rdata <= 8'h00;
    else if (io_req.rd) io_rdata <= next_rdata;
  end

  // ==========================================================
  // Assertions
  property p_mask_reserved;
    @(posedge clk) disable iff (!arst_n)
      (io_req.rd && io_req.addr == ADDR_GIMASK)
      |=> (io_rdata[7] == 1'b0 && io_rdata[3:0] == 4'h0);
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("reserved mask bits read non-zero");

  property p_level_flag;
    @(posedge clk) disable iff (!arst_n)
      (sense == SENSE_LOW) [*2] |-> !giflags[FLG_EXT_BIT];
  endproperty
  a_level_flag: assert property (p_level_flag)
    else $error("external flag set in low-level mode");

  property p_level_req;
    @(posedge clk) disable iff (!arst_n)
      (sense == SENSE_LOW && gie && gimask[GIM_EXT_BIT]
       && !pin_sync[EXT_PIN]) |-> irq_req[0];
  endproperty
  a_level_req: assert property (p_level_req)
    else $error("low level not requesting");

  property p_ext_gate;
    @(posedge clk) disable iff (!arst_n)
      irq_req[0] |-> (gie && gimask[GIM_EXT_BIT]);
  endproperty
  a_ext_gate: assert property (p_ext_gate)
    else $error("external request without enables");

  property p_pc_gate;
    @(posedge clk) disable iff (!arst_n)
      (irq_req[1] |-> gie && gimask[GIM_PC0_BIT])
      and (irq_req[2] |-> gie && gimask[GIM_PC1_BIT]);
  endproperty
  a_pc_gate: assert property (p_pc_gate)
    else $error("pin change request without enables");

  property p_pc0_set;
    @(posedge clk) disable iff (!arst_n)
      ($changed(pin_sync[0]) && pcmsk_low[0] && gimask[GIM_PC0_BIT])
      |=> giflags[FLG_PC0_BIT];
  endproperty
  a_pc0_set: assert property (p_pc0_set)
    else $error("pin change group zero flag not set");

  property p_pc1_ack;
    @(posedge clk) disable iff (!arst_n)
      (irq_ack[2] && !set_pc1) |=> !giflags[FLG_PC1_BIT];
  endproperty
  a_pc1_ack: assert property (p_pc1_ack)
    else $error("group one flag survived service");

  property p_toggle;
    @(posedge clk) disable iff (!arst_n)
      (io_req.wr && io_req.addr == ADDR_A_IN)
      |=> pin_out[7:0] == ($past(pin_out[7:0]) ^ $past(io_req.wdata));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("input register write did not toggle output");

  property p_unmasked;
    @(posedge clk) disable iff (!arst_n)
      (pcmsk_low == 8'h00 && !giflags[FLG_PC0_BIT]) |=> !giflags[FLG_PC0_BIT];
  endproperty
  a_unmasked: assert property (p_unmasked)
    else $error("masked pins raised group zero flag");

  property p_pc1_set;
    @(posedge clk) disable iff (!arst_n)
      ($changed(pin_sync[8]) && pcmsk_high[0] && gimask[GIM_PC1_BIT])
      |=> giflags[FLG_PC1_BIT];
  endproperty
  a_pc1_set: assert property (p_pc1_set)
    else $error("pin change group one flag not set");

  property p_ext_edge;
    @(posedge clk) disable iff (!arst_n)
      ((sense == SENSE_RISE && $rose(pin_sync[EXT_PIN]))
       || (sense == SENSE_FALL && $fell(pin_sync[EXT_PIN])))
      |=> giflags[FLG_EXT_BIT];
  endproperty
  a_ext_edge: assert property (p_ext_edge)
    else $error("external edge did not set flag");

  property p_ext_ack;
    @(posedge clk) disable iff (!arst_n)
      (irq_ack[0] && !set_ext) |=> !giflags[FLG_EXT_BIT];
  endproperty
  a_ext_ack: assert property (p_ext_ack)
    else $error("external flag survived service");

  c_ext_edge: cover property (@(posedge clk) disable iff (!arst_n)
    ext_trig ##1 irq_req[0]);
  c_pc1_req: cover property (@(posedge clk) disable iff (!arst_n)
    set_pc1 ##1 irq_req[2]);
  c_set_vs_clr: cover property (@(posedge clk) disable iff (!arst_n)
    set_pc0 && flag_clr[FLG_PC0_BIT]);
  c_level_req: cover property (@(posedge clk) disable iff (!arst_n)
    ext_level && irq_req[0]);

endmodule : gpp_top

`default_nettype wire

// [sim/gpp_pins_model.sv]
`default_nettype none

// ==========================================================
// Pads and outside circuitry on the twelve port pins
module gpp_pins_model (
  input  wire logic        clk,
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe_n,
  input  wire logic [11:0] pin_pullup,
  input  wire logic [11:0] ext_val,
  input  wire logic [11:0] ext_en,
  output logic [11:0]      pin_lvl
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [11:0] float_v = 12'h000;

  // Undriven lines without pull-up wander every cycle
  always_ff @(posedge clk) begin
    float_v <= ~float_v;
  end

  // Device drive first, then outside drive, then pull-up
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (!pin_oe_n[i]) pin_lvl[i] = pin_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pin_pullup[i]) pin_lvl[i] = 1'b1;
      else pin_lvl[i] = float_v[i];
    end
  end
endmodule : gpp_pins_model

`default_nettype wire

// [sim/gpp_top_test.sv]
`default_nettype none

module gpp_top_test
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Signals
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } gpp_row_t;

  localparam logic [3:0] WR  = 4'h8;
  localparam logic [3:0] RD  = 4'h4;
  localparam logic [3:0] SET = 4'h2;
  localparam logic [3:0] CLR = 4'h1;

  logic        clk        = 1'b0;
  logic        arst_n     = 1'b0;
  gpp_io_req_t io_req     = '0;
  logic [7:0]  io_rdata;
  logic        gie        = 1'b0;
  logic [2:0]  irq_ack    = 3'h0;
  logic [2:0]  irq_req;
  logic [11:0] pin_in;
  logic [11:0] pin_out;
  logic [11:0] pin_oe_n;
  logic [11:0] pin_pullup;
  logic [11:0] ext_val    = 12'h000;
  logic [11:0] ext_en     = 12'hFFF;
  logic [7:0]  rd;
  logic [4:0]  c;
  int          failures   = 0;
  int          n_tests    = 0;

  gpp_row_t rows [11] = '{
    '{ADDR_PCMSK_LOW, 8'hFF, 8'hFF}, '{ADDR_PCMSK_HIGH, 8'hFF, 8'h0F},
    '{ADDR_GIMASK, 8'hFF, 8'h70}, '{ADDR_A_OUT, 8'h55, 8'h55},
    '{ADDR_A_DIR, 8'hAA, 8'hAA}, '{ADDR_A_PUE, 8'h3C, 8'h3C},
    '{ADDR_B_OUT, 8'hFF, 8'h0F}, '{ADDR_B_DIR, 8'hF5, 8'h05},
    '{ADDR_B_PUE, 8'h0A, 8'h0A}, '{ADDR_SENSE, 8'hFF, 8'h03},
    '{6'h01, 8'hFF, 8'h00}};
  // Sense mode, level before, level after, flag expected
  logic [4:0] ext_cases [6] = '{5'h1B, 5'h1C, 5'h15, 5'h12, 5'h0B, 5'h0D};

  // ==========================================================
  // Design, pads, clock
  gpp_top uut (
    .clk        (clk),
    .arst_n     (arst_n),
    .io_req     (io_req),
    .io_rdata   (io_rdata),
    .gie        (gie),
    .irq_ack    (irq_ack),
    .irq_req    (irq_req),
    .pin_in     (pin_in),
    .pin_out    (pin_out),
    .pin_oe_n   (pin_oe_n),
    .pin_pullup (pin_pullup)
  );

  gpp_pins_model pads (
    .clk        (clk),
    .pin_out    (pin_out),
    .pin_oe_n   (pin_oe_n),
    .pin_pullup (pin_pullup),
    .ext_val    (ext_val),
    .ext_en     (ext_en),
    .pin_lvl    (pin_in)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Tasks
  task automatic chk_reg(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_vec(input string nm, input logic [11:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk_vec

  // One register access, held for one taking edge
  task automatic io_op(input logic [5:0] a, input logic [7:0] d,
                       input logic [3:0] k, input logic [2:0] b);
    @(posedge clk);
    io_req <= '{addr: a, wdata: d, wr: k[3], rd: k[2],
                bset: k[1], bclr: k[0], bitsel: b};
    @(posedge clk);
    io_req <= '0;
    #1 rd = io_rdata;
  endtask : io_op

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    io_op(a, 8'h00, RD, 3'd0);
    chk_reg($sformatf("reg %h", a), e, rd);
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic results;
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Watchdog
  initial begin
    #(25 * 5000);
    failures++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    tick(10);
    arst_n <= 1'b1;
    // Reset value, write, read back for every row
    foreach (rows[i]) begin
      rchk(rows[i].a, 8'h00);
      io_op(rows[i].a, rows[i].d, WR, 3'd0);
      rchk(rows[i].a, rows[i].e);
    end
    chk_vec("pin_out", 12'hF55, pin_out);
    chk_vec("pin_oe_n", 12'hA55, pin_oe_n);
    chk_vec("pin_pullup", 12'hA3C, pin_pullup);
    // Toggle through input register, then single-bit ops
    io_op(ADDR_A_IN, 8'h0F, WR, 3'd0);
    io_op(ADDR_A_IN, 8'h00, SET, 3'd7);
    rchk(ADDR_A_OUT, 8'hDA);
    io_op(ADDR_A_DIR, 8'h00, SET, 3'd0);
    io_op(ADDR_A_PUE, 8'h00, CLR, 3'd2);
    chk_vec("pin_oe_n", 12'hA54, pin_oe_n);
    chk_vec("pin_pullup", 12'hA38, pin_pullup);
    // Reset in mid-run tri-states before any edge
    @(posedge clk);
    #5 arst_n <= 1'b0;
    #1 chk_vec("pin_oe_n", 12'hFFF, pin_oe_n);
    chk_vec("pin_pullup", 12'h000, pin_pullup);
    @(posedge clk);
    arst_n <= 1'b1;
    gie <= 1'b1;
    // Pin-change groups
    io_op(ADDR_SENSE, 8'h03, WR, 3'd0);
    io_op(ADDR_GIMASK, 8'h70, WR, 3'd0);
    io_op(ADDR_PCMSK_LOW, 8'h01, WR, 3'd0);
    io_op(ADDR_PCMSK_HIGH, 8'h01, WR, 3'd0);
    io_op(ADDR_GIFLAGS, 8'hFF, WR, 3'd0);
    rchk(ADDR_GIFLAGS, 8'h00);
    @(posedge clk);
    ext_val[1] <= 1'b1;
    tick(4);
    #1 chk_vec("irq", 12'h000, {9'h0, irq_req});
    @(posedge clk);
    ext_val[0] <= 1'b1;
    tick(2);
    #1 chk_vec("irq", 12'h000, {9'h0, irq_req});
    tick(1);
    #1 chk_vec("irq", 12'h002, {9'h0, irq_req});
    @(posedge clk);
    irq_ack <= 3'b010;
    @(posedge clk);
    irq_ack <= 3'b000;
    #1 chk_vec("irq", 12'h000, {9'h0, irq_req});
    @(posedge clk);
    gie <= 1'b0;
    ext_val[0] <= 1'b0;
    tick(4);
    #1 chk_vec("irq", 12'h000, {9'h0, irq_req});
    rchk(ADDR_GIFLAGS, 8'h01);
    rchk(ADDR_A_IN, 8'h02);
    @(posedge clk);
    gie <= 1'b1;
    tick(2);
    #1 chk_vec("irq", 12'h002, {9'h0, irq_req});
    io_op(ADDR_GIFLAGS, 8'h01, WR, 3'd0);
    chk_vec("irq", 12'h000, {9'h0, irq_req});
    @(posedge clk);
    ext_val[8] <= 1'b1;
    tick(4);
    #1 chk_vec("irq", 12'h004, {9'h0, irq_req});
    rchk(ADDR_GIFLAGS, 8'h02);
    io_op(ADDR_GIFLAGS, 8'h00, SET, 3'd1);
    rchk(ADDR_GIFLAGS, 8'h00);
    // Group one flag cleared by its service pulse
    @(posedge clk);
    ext_val[8] <= 1'b0;
    tick(4);
    #1 chk_vec("irq", 12'h004, {9'h0, irq_req});
    @(posedge clk);
    irq_ack <= 3'b100;
    @(posedge clk);
    irq_ack <= 3'b000;
    #1 chk_vec("irq", 12'h000, {9'h0, irq_req});
    // External pin in each edge mode
    foreach (ext_cases[i]) begin
      c = ext_cases[i];
      @(posedge clk);
      ext_val[EXT_PIN] <= c[2];
      tick(4);
      io_op(ADDR_SENSE, {6'h00, c[4:3]}, WR, 3'd0);
      io_op(ADDR_GIFLAGS, 8'hFF, WR, 3'd0);
      @(posedge clk);
      ext_val[EXT_PIN] <= c[1];
      tick(4);
      #1 chk_vec("ext irq", {11'h0, c[0]}, {9'h0, irq_req});
      rchk(ADDR_GIFLAGS, {1'b0, c[0], 6'h00});
    end
    // Low level sensing, entered with the external flag pending
    io_op(ADDR_SENSE, 8'h00, WR, 3'd0);
    tick(1);
    #1 chk_vec("irq", 12'h001, {9'h0, irq_req});
    rchk(ADDR_GIFLAGS, 8'h00);
    @(posedge clk);
    ext_val[EXT_PIN] <= 1'b1;
    tick(4);
    #1 chk_vec("irq", 12'h000, {9'h0, irq_req});
    // Pin driven as output still raises the external flag
    io_op(ADDR_SENSE, 8'h01, WR, 3'd0);
    io_op(ADDR_B_OUT, 8'h04, WR, 3'd0);
    io_op(ADDR_B_DIR, 8'h00, SET, 3'd2);
    io_op(ADDR_GIFLAGS, 8'hFF, WR, 3'd0);
    io_op(ADDR_B_IN, 8'h00, SET, 3'd2);
    tick(4);
    rchk(ADDR_GIFLAGS, 8'h40);
    io_op(ADDR_GIMASK, 8'h00, CLR, 3'd6);
    chk_vec("irq", 12'h000, {9'h0, irq_req});
    // Service pulse clears the still pending external flag
    @(posedge clk);
    irq_ack <= 3'b001;
    @(posedge clk);
    irq_ack <= 3'b000;
    rchk(ADDR_GIFLAGS, 8'h00);
    results();
  end
endmodule : gpp_top_test

`default_nettype wire
